// ==== src/ppic_bank.sv ====
// Per-port PVID insertion and pass-all control registers with APB slave
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "ppic_defs.svh"

module ppic_bank
(
    input  wire logic        core_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [2:0]  src_port_i,
    input  wire logic        src_tagged_i,
    input  wire logic [11:0] src_pvid_i,
    output logic      [4:0]  pass_all_o,
    output logic      [4:0]  insert_egress_o,
    output logic      [11:0] insert_vid_o
);

    ppic_pkg::ppic_state_t state;
    ppic_pkg::ppic_state_t next_state;

    logic       access;
    logic [2:0] hit_idx;
    logic       hit_port;
    logic       hit_glb;
    logic [4:0] map_sel;

    assign access   = psel_i & penable_i;
    assign hit_glb  = (paddr_i == `PPIC_OFF_GLOBAL);

    always_comb
    begin
        hit_idx  = 3'h0;
        hit_port = 1'b0;
        unique case (paddr_i)
            `PPIC_OFF_PORT1: begin hit_idx = 3'h0; hit_port = 1'b1; end
            `PPIC_OFF_PORT2: begin hit_idx = 3'h1; hit_port = 1'b1; end
            `PPIC_OFF_PORT3: begin hit_idx = 3'h2; hit_port = 1'b1; end
            `PPIC_OFF_PORT4: begin hit_idx = 3'h3; hit_port = 1'b1; end
            `PPIC_OFF_PORT5: begin hit_idx = 3'h4; hit_port = 1'b1; end
            default:         begin hit_idx = 3'h0; hit_port = 1'b0; end
        endcase
    end

    always_comb
    begin
        next_state         = state;
        next_state.pslverr = 1'b0;
        if (psel_i && !penable_i)
        begin
            next_state.prdata = 32'h0000_0000;
            if (hit_port)
                next_state.prdata = {24'h00_0000, state.port_ctrl[hit_idx]};
            else if (hit_glb)
                next_state.prdata = {24'h00_0000, state.glb_ctrl};
            next_state.pslverr = !(hit_port || hit_glb);
        end
        if (access && pwrite_i && pstrb_i[0])
        begin
            if (hit_port)
                next_state.port_ctrl[hit_idx] = (pwdata_i[7:0] & `PPIC_PORT_WMASK)
                    | (state.port_ctrl[hit_idx] & ~`PPIC_PORT_WMASK);
            else if (hit_glb)
                next_state.glb_ctrl = pwdata_i[7:0] & `PPIC_GLB_WMASK;
        end
        if (access)
            next_state.pslverr = state.pslverr;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state.port_ctrl <= {`PPIC_NUM_PORTS{`PPIC_PORT_RESET}};
            state.glb_ctrl  <= `PPIC_GLB_RESET;
            state.prdata    <= 32'h0000_0000;
            state.pslverr   <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign pready_o  = 1'b1;
    assign prdata_o  = state.prdata;
    assign pslverr_o = access & state.pslverr;

    // Pass-all enables; software restricts use to RX sniffing
    always_comb
    begin
        for (int i = 0; i < `PPIC_NUM_PORTS; i++)
            pass_all_o[i] = state.port_ctrl[i][`PPIC_BIT_PASS_ALL];
    end

    // Egress mapping of the four insertion bits for the current source port
    always_comb
    begin
        logic [7:0] r;
        r       = 8'h00;
        map_sel = 5'h00;
        if (src_port_i < 3'h5)
        begin
            r = state.port_ctrl[src_port_i];
            map_sel[4] = r[`PPIC_BIT_INS_HIGH];
            if (src_port_i <= 3'h2)
                map_sel[3] = r[`PPIC_BIT_INS_2HIGH];
            else
                map_sel[2] = r[`PPIC_BIT_INS_2HIGH];
            if (src_port_i <= 3'h1)
                map_sel[2] = map_sel[2] | r[`PPIC_BIT_INS_2LOW];
            else
                map_sel[1] = r[`PPIC_BIT_INS_2LOW];
            if (src_port_i == 3'h0)
                map_sel[1] = map_sel[1] | r[`PPIC_BIT_INS_LOW];
            else
                map_sel[0] = r[`PPIC_BIT_INS_LOW];
        end
        if (!state.glb_ctrl[`PPIC_BIT_GLB_INS] || src_tagged_i)
            map_sel = 5'h00;
    end

    assign insert_egress_o = map_sel;
    assign insert_vid_o    = src_pvid_i;

endmodule // ppic_bank

// ==== src/ppic_defs.svh ====
// Register offsets, field positions and reset values of the PVID insertion control bank
`ifndef PPIC_DEFS_SVH
`define PPIC_DEFS_SVH

`define PPIC_NUM_PORTS      5
`define PPIC_OFF_PORT1      12'h0B0
`define PPIC_OFF_PORT2      12'h0C0
`define PPIC_OFF_PORT3      12'h0D0
`define PPIC_OFF_PORT4      12'h0E0
`define PPIC_OFF_PORT5      12'h0F0
`define PPIC_OFF_GLOBAL     12'h087
`define PPIC_BIT_RSVD7      7
`define PPIC_BIT_PASS_ALL   6
`define PPIC_BIT_INS_HIGH   3
`define PPIC_BIT_INS_2HIGH  2
`define PPIC_BIT_INS_2LOW   1
`define PPIC_BIT_INS_LOW    0
`define PPIC_BIT_GLB_INS    2
`define PPIC_PORT_RESET     8'h80
`define PPIC_PORT_WMASK     8'h4F
`define PPIC_GLB_RESET      8'h00
`define PPIC_GLB_WMASK      8'h04

`endif

// ==== src/ppic_pkg.sv ====
// Types of the PVID insertion control bank
package ppic_pkg;

    typedef struct packed {
        logic [4:0][7:0] port_ctrl;
        logic [7:0]      glb_ctrl;
        logic [31:0]     prdata;
        logic            pslverr;
    } ppic_state_t;

endpackage

// ==== tb/port_pvid_insert_control_test.sv ====
// Self-checking testbench for the PVID insertion control bank
`timescale 1ns/1ps
module port_pvid_insert_control_test;
    logic        core_clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic        src_tagged_i = 0, pready_o, pslverr_o, err;
    logic [11:0] paddr_i = 12'h000, src_pvid_i = 12'h5A3, insert_vid_o;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0]  pstrb_i = 4'h1;
    logic [2:0]  src_port_i = 3'h0;
    logic [4:0]  pass_all_o, insert_egress_o;
    int          num_errors = 0, comparisons = 0;
    logic [4:0]  tbl [4][5] = '{'{5'h02, 5'h01, 5'h01, 5'h01, 5'h01},
        '{5'h04, 5'h04, 5'h02, 5'h02, 5'h02}, '{5'h08, 5'h08, 5'h08, 5'h04, 5'h04},
        '{5'h10, 5'h10, 5'h10, 5'h10, 5'h10}};
    ppic_bank uut (.*);
    initial forever #12.5 core_clk_i = ~core_clk_i;
    task automatic finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n = 0;
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1 && ++n < 50);
        if (n == 50) begin num_errors++; finish_test(); end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic src(logic [2:0] p, logic t, logic [4:0] exp);
        @(posedge core_clk_i);
        src_port_i <= p;
        src_tagged_i <= t;
        @(negedge core_clk_i);
        check("egress", exp, insert_egress_o);
    endtask
    initial
    begin
        repeat (10) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        for (int p = 0; p < 5; p++)
        begin
            apb(0, 12'h0B0 + 12'(p << 4), 0);
            check("reset", 32'h80, rd);
            apb(1, 12'h0B0 + 12'(p << 4), 32'hFF);
            apb(0, 12'h0B0 + 12'(p << 4), 0);
            check("rw", 32'hCF, rd);
        end
        check("pass_all", 5'h1F, pass_all_o);
        apb(0, 12'h0A0, 0);
        check("slverr", 1, err);
        $display("register test done");
        apb(1, 12'h087, 32'h04);
        for (int b = 0; b < 4; b++)
        begin
            for (int p = 0; p < 5; p++) apb(1, 12'h0B0 + 12'(p << 4), 32'h1 << b);
            for (int p = 0; p < 5; p++) src(3'(p), 0, tbl[b][p]);
            check("vid", 12'h5A3, insert_vid_o);
            src(3'h0, 1, 5'h00);
            src(3'h5, 0, 5'h00);
        end
        check("pass_off", 5'h00, pass_all_o);
        apb(1, 12'h087, 32'h00);
        src(3'h4, 0, 5'h00);
        $display("insertion test done");
        finish_test();
    end
endmodule // port_pvid_insert_control_test

// ==== tb/ppic_bank_sva.sv ====
// Assertion checker for the PVID insertion control bank
`timescale 1ns/1ps
module ppic_bank_sva
(
    input wire logic        core_clk_i, arst_n_i, psel_i, penable_i, pwrite_i, src_tagged_i,
    input wire logic [11:0] paddr_i, src_pvid_i, insert_vid_o,
    input wire logic [31:0] pwdata_i, prdata_o,
    input wire logic [3:0]  pstrb_i,
    input wire logic        pready_o, pslverr_o,
    input wire logic [2:0]  src_port_i,
    input wire logic [4:0]  pass_all_o, insert_egress_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_acc; psel_i && penable_i; endsequence
    sequence s_wr(a); s_acc ##0 (pwrite_i && pstrb_i[0] && paddr_i == a); endsequence
    a_ready_now: assert property (s_acc |-> pready_o) else $error("pready low");
    a_unmapped_err: assert property (s_acc ##0 paddr_i == 12'h0A0 |-> pslverr_o)
        else $error("no slave error");
    a_read_upper: assert property (s_acc ##0 !pwrite_i |-> prdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_pass_write: assert property (s_wr(12'h0B0) |=> pass_all_o[0] == $past(pwdata_i[6]))
        else $error("pass all not written");
    a_pass_hold: assert property (!$stable(pass_all_o) |-> $past(psel_i && penable_i && pwrite_i))
        else $error("pass all changed alone");
    a_glb_off: assert property (s_wr(12'h087) ##0 !pwdata_i[2] |=> insert_egress_o == 5'h00)
        else $error("insertion while disabled");
    a_src_range: assert property (src_port_i > 3'h4 |-> insert_egress_o == 5'h00)
        else $error("insertion for bad source");
    a_tag_none: assert property (src_tagged_i |-> insert_egress_o == 5'h00)
        else $error("insertion on tagged frame");
    a_vid_copy: assert property (insert_egress_o != 5'h00 |-> insert_vid_o == src_pvid_i)
        else $error("wrong inserted vid");
endmodule // ppic_bank_sva

bind ppic_bank ppic_bank_sva u_sva (.*);
